// >>> sfpec_host_model.sv
// host side of the serial link: sends command frames msb first
`timescale 1ns/1ps
`default_nettype none
module sfpec_host_model (
  output logic sck,
  output logic csN,
  output logic si
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
  end

  // hb header bits, then nd data bytes whose byte k is d0 + k*11h
  task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int hb,
      input int nd, input logic [7:0] d0);
    logic [31:0] h;
    logic [7:0] b;
    h = {op, adr};
    #7 csN = 1'b0;
    for (int i = 0; i < hb + nd * 8; i++) begin
      if (i < 32) begin
        si = h[31 - i];
      end else begin
        b = d0 + 8'((i - 32) / 8 * 8'h11);
        si = b[7 - (i - 32) % 8];
      end
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
    #8 csN = 1'b1;
    // released line must not keep showing the last bit
    si = ~si;
    // deselect gap long enough for the system clock to see the rise
    #200;
  endtask : frame
endmodule : sfpec_host_model
`default_nettype wire

// >>> sfpec_link_if.sv
// signals between the serial link receiver and the sequencer core
`timescale 1ns/1ps
`default_nettype none
interface sfpec_link_if;
  logic sckClk;
  logic csN;
  logic siBit;
  logic linkClr;
  logic hdrTog;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic dataTog;
  logic dataBuf;
  logic [8:0] dataIdx;
  logic [7:0] dataByte;
  modport rx (
    input sckClk, csN, siBit, linkClr,
    output hdrTog, opcode, addr, dataTog, dataBuf, dataIdx, dataByte
  );
  modport core (
    output sckClk, csN, siBit, linkClr,
    input hdrTog, opcode, addr, dataTog, dataBuf, dataIdx, dataByte
  );
endinterface : sfpec_link_if
`default_nettype wire

// >>> sfpec_link_rx.sv
// serial clock domain receiver: header capture and buffer data bytes
`timescale 1ns/1ps
`default_nettype none
module sfpec_link_rx (
  sfpec_link_if.rx io
);
  import sfpec_pkg::*;

  logic [5:0] bitCnt;
  logic [2:0] dataBits;
  logic [31:0] hdr;
  logic [6:0] byteShift;
  logic [8:0] byteIdx;
  logic loadCmd;

  assign io.opcode = hdr[31:24];
  assign io.addr = hdr[23:0];

  // frame position counters end with the frame itself
  always_ff @(posedge io.sckClk or posedge io.csN) begin
    if (io.csN) begin
      bitCnt <= 6'h00;
      dataBits <= 3'h0;
    end else if (bitCnt != HDR_BITS) begin
      bitCnt <= bitCnt + 6'h01;
    end else begin
      dataBits <= dataBits + 3'h1;
    end
  end

  // si sampled on the rising serial clock, msb first
  always_ff @(posedge io.sckClk or posedge io.linkClr) begin
    if (io.linkClr) begin
      hdr <= 32'h0000_0000;
      byteShift <= 7'h00;
      byteIdx <= 9'h000;
      loadCmd <= 1'b0;
      io.hdrTog <= 1'b0;
      io.dataTog <= 1'b0;
      io.dataBuf <= 1'b0;
      io.dataIdx <= 9'h000;
      io.dataByte <= 8'h00;
    end else if (bitCnt != HDR_BITS) begin
      hdr <= {hdr[30:0], io.siBit};
      if (bitCnt == HDR_LAST) begin
        io.hdrTog <= ~io.hdrTog;
        byteIdx <= {hdr[7:0], io.siBit};
        loadCmd <= sfpec_is_load(hdr[30:23]);
      end
    end else begin
      byteShift <= {byteShift[5:0], io.siBit};
      if (dataBits == 3'h7 && loadCmd) begin
        io.dataByte <= {byteShift, io.siBit};
        io.dataIdx <= byteIdx;
        io.dataBuf <= sfpec_buf_of(hdr[31:24]);
        io.dataTog <= ~io.dataTog;
        byteIdx <= (byteIdx >= LAST_IDX) ? 9'h000 : byteIdx + 9'h001;
      end
    end
  end

  data_idx_a: assert property (@(posedge io.sckClk) disable iff (io.linkClr)
    (bitCnt == HDR_BITS) |-> (byteIdx <= LAST_IDX))
    else $error("buffer index beyond last byte");

endmodule : sfpec_link_rx
`default_nettype wire

// >>> sfpec_pkg.sv
// shared constants, types and opcode decoding for the flash command sequencer
package sfpec_pkg;

  localparam logic [7:0] OP_WR_B1 = 8'h84;
  localparam logic [7:0] OP_WR_B2 = 8'h87;
  localparam logic [7:0] OP_PGE_B1 = 8'h83;
  localparam logic [7:0] OP_PGE_B2 = 8'h86;
  localparam logic [7:0] OP_PG_B1 = 8'h88;
  localparam logic [7:0] OP_PG_B2 = 8'h89;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_THRU_B1 = 8'h82;
  localparam logic [7:0] OP_THRU_B2 = 8'h85;
  localparam logic [7:0] OP_XFER_B1 = 8'h53;
  localparam logic [7:0] OP_XFER_B2 = 8'h55;
  localparam logic [7:0] OP_CMP_B1 = 8'h60;
  localparam logic [7:0] OP_CMP_B2 = 8'h61;
  localparam logic [7:0] OP_REWR_B1 = 8'h58;
  localparam logic [7:0] OP_REWR_B2 = 8'h59;

  localparam int PAGE_BYTES = 264;
  localparam int PAGE_W = 10;
  localparam int IDX_W = 9;
  localparam int MEM_ADDR_W = PAGE_W + IDX_W;
  localparam logic [8:0] LAST_IDX = 9'h107;
  localparam logic [2:0] LAST_BLOCK_PAGE = 3'h7;
  // header field positions inside the 24 address bits, then the 32-bit header length and last bit count
  localparam int PAGE_MSB = 18;
  localparam int PAGE_LSB = 9;
  localparam int BLOCK_LSB = 12;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h1F;

  localparam logic [2:0] STAT_DENSITY = 3'h2;
  localparam logic [2:0] STAT_LOW = 3'h0;

  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned EP_TIME_US = 20000;
  localparam int unsigned P_TIME_US = 14000;
  localparam int unsigned PE_TIME_US = 8000;
  localparam int unsigned BE_TIME_US = 12000;
  localparam int unsigned XFR_TIME_US = 300;

  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_PROG_ERASE = 3'b001,
    K_PROG = 3'b010,
    K_PAGE_ERASE = 3'b011,
    K_BLOCK_ERASE = 3'b100,
    K_XFER = 3'b101,
    K_CMP = 3'b110,
    K_REWRITE = 3'b111
  } sfpec_kind_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_READ = 3'b001,
    S_ERASE = 3'b010,
    S_PROG = 3'b011,
    S_HOLD = 3'b100
  } sfpec_state_e;

  function automatic sfpec_kind_e sfpec_kind_of(input logic [7:0] op);
    case (op)
      OP_PGE_B1, OP_PGE_B2, OP_THRU_B1, OP_THRU_B2: sfpec_kind_of = K_PROG_ERASE;
      OP_PG_B1, OP_PG_B2: sfpec_kind_of = K_PROG;
      OP_PAGE_ERASE: sfpec_kind_of = K_PAGE_ERASE;
      OP_BLOCK_ERASE: sfpec_kind_of = K_BLOCK_ERASE;
      OP_XFER_B1, OP_XFER_B2: sfpec_kind_of = K_XFER;
      OP_CMP_B1, OP_CMP_B2: sfpec_kind_of = K_CMP;
      OP_REWR_B1, OP_REWR_B2: sfpec_kind_of = K_REWRITE;
      default: sfpec_kind_of = K_NONE;
    endcase
  endfunction : sfpec_kind_of

  // opcodes that are followed by data bytes for a buffer
  function automatic logic sfpec_is_load(input logic [7:0] op);
    sfpec_is_load = (op == OP_WR_B1) || (op == OP_WR_B2) ||
                    (op == OP_THRU_B1) || (op == OP_THRU_B2);
  endfunction : sfpec_is_load

  // 1 selects the second buffer
  function automatic logic sfpec_buf_of(input logic [7:0] op);
    sfpec_buf_of = (op == OP_WR_B2) || (op == OP_PGE_B2) || (op == OP_PG_B2) ||
                   (op == OP_THRU_B2) || (op == OP_XFER_B2) || (op == OP_CMP_B2) ||
                   (op == OP_REWR_B2);
  endfunction : sfpec_buf_of

endpackage : sfpec_pkg

// >>> sfpec_top.sv
// flash program, erase, transfer and compare command sequencer
// Behaviour
// - buffer write: opcode, 15 ignored, 9-bit index
// - data bytes stored sequentially, wrap, until deselect
// - program-with-erase: opcode, 5, 10-bit page, 9
// - on deselect erase page then program buffer
// - program without erase on deselect, same layout
// - page erase opcode, page erased on deselect
// - block erase: eight pages erased on deselect
// - block is page bits 9..3, low ignored
// - program through buffer: page plus byte index
// - load buffer, then erase and program page
// - page to buffer copy starts on deselect
// - compare all page bytes against buffer
// - compare result written into status bit 6
// - rewrite: copy, erase, program same page
// - busy shown for whole self-timed operation
// - bit 7 ready, bit 6 mismatch flag
// - input sampled on rising serial clock
`timescale 1ns/1ps
`default_nettype none
module sfpec_top #(
  parameter int unsigned ERASE_PROGRAM_TIME_MAX_US = sfpec_pkg::EP_TIME_US,
  parameter int unsigned PROGRAM_TIME_MAX_US = sfpec_pkg::P_TIME_US,
  parameter int unsigned PAGE_ERASE_TIME_MAX_US = sfpec_pkg::PE_TIME_US,
  parameter int unsigned BLOCK_ERASE_TIME_MAX_US = sfpec_pkg::BE_TIME_US,
  parameter int unsigned TRANSFER_COMPARE_TIME_US = sfpec_pkg::XFR_TIME_US
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic linkSck,
  input wire logic linkCsN,
  input wire logic linkSi,
  input wire logic [7:0] memRdData,
  output logic [sfpec_pkg::MEM_ADDR_W-1:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWrEn,
  output logic memEraseEn,
  output logic [7:0] statusByte,
  output logic busyOe,
  output logic busyOut
);
  import sfpec_pkg::*;

  localparam int unsigned EP_CYC = ERASE_PROGRAM_TIME_MAX_US * CLK_MHZ;
  localparam int unsigned P_CYC = PROGRAM_TIME_MAX_US * CLK_MHZ;
  localparam int unsigned PE_CYC = PAGE_ERASE_TIME_MAX_US * CLK_MHZ;
  localparam int unsigned BE_CYC = BLOCK_ERASE_TIME_MAX_US * CLK_MHZ;
  localparam int unsigned XFR_CYC = TRANSFER_COMPARE_TIME_US * CLK_MHZ;

  sfpec_link_if lnk ();

  logic linkClr;
  logic csS1;
  logic csS2;
  logic csPrev;
  logic hdrS1;
  logic hdrS2;
  logic hdrSeen;
  logic datS1;
  logic datS2;
  logic dataSeen;
  logic csRise;
  logic hdrNew;
  logic dataNew;
  logic opStart;
  sfpec_kind_e cmdKind;
  logic cmdBuf;
  sfpec_state_e firstState;
  logic [31:0] cmdLimit;

  sfpec_state_e state;
  sfpec_kind_e opKind;
  logic opBuf;
  logic [PAGE_W-1:0] opPage;
  logic [2:0] pageCnt;
  logic [IDX_W-1:0] idx;
  logic [31:0] timer;
  logic [31:0] opLimit;
  logic pipeValid;
  logic pipeProg;
  logic [IDX_W-1:0] pipeIdx;
  logic [7:0] bufRd;
  logic mismatch;
  logic compFlag;
  logic [7:0] bufMem [0:1][0:PAGE_BYTES-1];

  assign lnk.sckClk = linkSck;
  assign lnk.csN = linkCsN;
  assign lnk.siBit = linkSi;
  assign lnk.linkClr = linkClr;

  sfpec_link_rx uRx (
    .io(lnk.rx)
  );

  // clears the serial side while the system reset is applied
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      linkClr <= 1'b1;
    end else if (ce) begin
      linkClr <= 1'b0;
    end
  end

  // select level and link toggles cross on two flops each
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      csS1 <= 1'b1;
      csS2 <= 1'b1;
      csPrev <= 1'b1;
      hdrS1 <= 1'b0;
      hdrS2 <= 1'b0;
      datS1 <= 1'b0;
      datS2 <= 1'b0;
    end else if (ce) begin
      csS1 <= linkCsN;
      csS2 <= csS1;
      csPrev <= csS2;
      hdrS1 <= lnk.hdrTog;
      hdrS2 <= hdrS1;
      datS1 <= lnk.dataTog;
      datS2 <= datS1;
    end
  end

  assign csRise = csS2 && !csPrev;
  assign hdrNew = hdrS2 != hdrSeen;
  assign dataNew = datS2 != dataSeen;
  assign cmdKind = sfpec_kind_of(lnk.opcode);
  assign cmdBuf = sfpec_buf_of(lnk.opcode);
  // only a full header seen in this frame starts work, and never while busy
  assign opStart = csRise && hdrNew && cmdKind != K_NONE && state == S_IDLE;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hdrSeen <= 1'b0;
      dataSeen <= 1'b0;
    end else if (ce) begin
      if (csRise) begin
        hdrSeen <= hdrS2;
      end
      dataSeen <= datS2;
    end
  end

  always_comb begin
    case (cmdKind)
      K_PROG_ERASE: firstState = S_ERASE;
      K_PROG: firstState = S_PROG;
      K_PAGE_ERASE: firstState = S_ERASE;
      K_BLOCK_ERASE: firstState = S_ERASE;
      K_XFER: firstState = S_READ;
      K_CMP: firstState = S_READ;
      K_REWRITE: firstState = S_READ;
      default: firstState = S_IDLE;
    endcase
  end

  always_comb begin
    case (cmdKind)
      K_PROG_ERASE: cmdLimit = EP_CYC;
      K_REWRITE: cmdLimit = EP_CYC;
      K_PROG: cmdLimit = P_CYC;
      K_PAGE_ERASE: cmdLimit = PE_CYC;
      K_BLOCK_ERASE: cmdLimit = BE_CYC;
      K_XFER: cmdLimit = XFR_CYC;
      K_CMP: cmdLimit = XFR_CYC;
      default: cmdLimit = 32'h0000_0000;
    endcase
  end

  // self-timed sequence: read page, erase, program buffer, then hold
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= S_IDLE;
      opKind <= K_NONE;
      opBuf <= 1'b0;
      opPage <= 10'h000;
      pageCnt <= 3'h0;
      idx <= 9'h000;
      timer <= 32'h0000_0000;
      opLimit <= 32'h0000_0000;
    end else if (ce) begin
      timer <= timer + 32'h0000_0001;
      case (state)
        S_IDLE: begin
          if (opStart) begin
            opKind <= cmdKind;
            opBuf <= cmdBuf;
            if (cmdKind == K_BLOCK_ERASE) begin
              opPage <= {lnk.addr[PAGE_MSB:BLOCK_LSB], 3'h0};
            end else begin
              opPage <= lnk.addr[PAGE_MSB:PAGE_LSB];
            end
            pageCnt <= 3'h0;
            idx <= 9'h000;
            timer <= 32'h0000_0000;
            opLimit <= cmdLimit;
            state <= firstState;
          end
        end
        S_READ: begin
          idx <= idx + 9'h001;
          if (idx == LAST_IDX) begin
            idx <= 9'h000;
            state <= (opKind == K_REWRITE) ? S_ERASE : S_HOLD;
          end
        end
        S_ERASE: begin
          pageCnt <= pageCnt + 3'h1;
          if (opKind != K_BLOCK_ERASE || pageCnt == LAST_BLOCK_PAGE) begin
            if (opKind == K_PAGE_ERASE || opKind == K_BLOCK_ERASE) begin
              state <= S_HOLD;
            end else begin
              state <= S_PROG;
            end
          end
        end
        S_PROG: begin
          idx <= idx + 9'h001;
          if (idx == LAST_IDX) begin
            idx <= 9'h000;
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (timer >= opLimit && !pipeValid) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // buffer read is registered alongside the array address it pairs with
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pipeValid <= 1'b0;
      pipeProg <= 1'b0;
      pipeIdx <= 9'h000;
      bufRd <= 8'h00;
    end else if (ce) begin
      pipeValid <= state == S_READ || state == S_PROG;
      pipeProg <= state == S_PROG;
      pipeIdx <= idx;
      bufRd <= bufMem[opBuf][idx];
    end
  end

  // engine page reads into the busy buffer win the write port; link bytes land otherwise
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (pipeValid && !pipeProg && opKind != K_CMP) begin
        bufMem[opBuf][pipeIdx] <= memRdData;
      end else if (dataNew) begin
        bufMem[lnk.dataBuf][lnk.dataIdx] <= lnk.dataByte;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mismatch <= 1'b0;
      compFlag <= 1'b0;
    end else if (ce) begin
      if (opStart) begin
        mismatch <= 1'b0;
      end else if (pipeValid && opKind == K_CMP) begin
        if (memRdData != bufRd) begin
          mismatch <= 1'b1;
        end
        if (pipeIdx == LAST_IDX) begin
          compFlag <= mismatch || (memRdData != bufRd);
        end
      end
    end
  end

  // array port: read address, page erase strobe, program write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      memAddr <= 19'h00000;
      memWrData <= 8'h00;
      memWrEn <= 1'b0;
      memEraseEn <= 1'b0;
    end else if (ce) begin
      memWrEn <= pipeValid && pipeProg;
      memEraseEn <= state == S_ERASE;
      memWrData <= bufRd;
      if (state == S_ERASE) begin
        if (opKind == K_BLOCK_ERASE) begin
          memAddr <= {opPage[PAGE_W-1:3], pageCnt, 9'h000};
        end else begin
          memAddr <= {opPage, 9'h000};
        end
      end else if (state == S_READ) begin
        memAddr <= {opPage, idx};
      end else begin
        memAddr <= {opPage, pipeIdx};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      statusByte <= {1'b1, 1'b0, STAT_DENSITY, STAT_LOW};
      busyOe <= 1'b0;
      busyOut <= 1'b0;
    end else if (ce) begin
      statusByte <= {state == S_IDLE, compFlag, STAT_DENSITY, STAT_LOW};
      busyOe <= state != S_IDLE;
      busyOut <= 1'b0;
    end
  end

  start_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (opStart && ce) ##1 ce |=> busyOe && !statusByte[7])
    else $error("busy not shown after start");

  ready_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    statusByte[7] == !busyOe)
    else $error("ready bit disagrees with busy pin");

  comp_update_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ce && pipeValid && opKind == K_CMP && pipeIdx == LAST_IDX &&
     memRdData != bufRd) ##1 ce |=> statusByte[6])
    else $error("compare mismatch not reported");

  erase_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (memEraseEn && $past(ce)) |-> $past(state) == S_ERASE && opKind != K_PROG)
    else $error("erase without erase phase");

  block_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (memEraseEn && opKind == K_BLOCK_ERASE) |-> memAddr[PAGE_MSB:BLOCK_LSB] == opPage[9:3])
    else $error("block erase outside addressed block");

  prog_no_erase_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (opKind == K_PROG && state != S_IDLE) |-> !memEraseEn)
    else $error("erase during plain program");

  short_frame_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ce && csRise && !hdrNew && state == S_IDLE) |=> state == S_IDLE)
    else $error("operation started by short frame");

  cmp_no_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (opKind == K_CMP || opKind == K_XFER) |-> !memWrEn && !memEraseEn)
    else $error("array changed by read-only operation");

endmodule : sfpec_top
`default_nettype wire

// >>> tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfpec_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  wire logic linkSck;
  wire logic linkCsN;
  wire logic linkSi;
  wire logic [7:0] memRdData;
  logic [MEM_ADDR_W-1:0] memAddr;
  logic [7:0] memWrData;
  logic memWrEn;
  logic memEraseEn;
  logic [7:0] statusByte;
  logic busyOe;
  logic busyOut;
  logic [7:0] mem [0:(1 << MEM_ADDR_W) - 1];
  int error_cnt = 0;
  int tests_run = 0;

  always #25 clk_sys = ~clk_sys;

  sfpec_top #(
    .ERASE_PROGRAM_TIME_MAX_US(1), .PROGRAM_TIME_MAX_US(1), .PAGE_ERASE_TIME_MAX_US(1),
    .BLOCK_ERASE_TIME_MAX_US(1), .TRANSFER_COMPARE_TIME_US(1)
  ) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .linkSck(linkSck), .linkCsN(linkCsN),
    .linkSi(linkSi), .memRdData(memRdData), .memAddr(memAddr), .memWrData(memWrData),
    .memWrEn(memWrEn), .memEraseEn(memEraseEn), .statusByte(statusByte),
    .busyOe(busyOe), .busyOut(busyOut)
  );

  sfpec_host_model host (.sck(linkSck), .csN(linkCsN), .si(linkSi));

  // array model: erase sets a page to ones, programming can only clear bits
  always @(posedge clk_sys) begin
    if (memEraseEn === 1'b1) begin
      for (int i = 0; i < PAGE_BYTES; i++) mem[{memAddr[18:9], 9'(i)}] <= 8'hFF;
    end
    if (memWrEn === 1'b1) mem[memAddr] <= mem[memAddr] & memWrData;
  end
  assign memRdData = mem[memAddr];

  function automatic logic [23:0] pa(input int p);
    pa = {5'h00, 10'(p), 9'h000};
  endfunction : pa

  function automatic logic [18:0] ma(input int p, input int b);
    ma = {10'(p), 9'(b)};
  endfunction : ma

  task automatic results();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic wait_done();
    int n;
    n = 0;
    while (busyOe !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("busyOe", 8'h02, {6'h00, busyOe, busyOut});
    chk("statusBusy", 8'h10, statusByte & 8'hBF);
    n = 0;
    while (busyOe !== 1'b0 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 4000) begin
      error_cnt++;
      results();
    end
    chk("statusReady", 8'h90, statusByte & 8'hBF);
    repeat (4) @(negedge clk_sys);
  endtask : wait_done

  task automatic cmd(input logic [7:0] op, input int p);
    host.frame(op, pa(p), 32, 0, 8'h00);
    wait_done();
  endtask : cmd

  task automatic t_reset();
    chk("statusReset", 8'h90, statusByte);
    chk("busyOut", 8'h00, {6'h00, busyOe, busyOut});
  endtask : t_reset

  task automatic t_prog_erase();
    host.frame(OP_WR_B2, 24'h000106, 32, 3, 8'hA0);
    repeat (8) @(negedge clk_sys);
    mem[ma(3, 100)] = 8'h00;
    cmd(OP_PGE_B2, 3);
    chk("wrap262", 8'hA0, mem[ma(3, 262)]);
    chk("wrap263", 8'hB1, mem[ma(3, 263)]);
    chk("wrap0", 8'hC2, mem[ma(3, 0)]);
    chk("erased100", 8'hA4, mem[ma(3, 100)]);
  endtask : t_prog_erase

  task automatic t_prog_only();
    mem[ma(5, 1)] = 8'hF0;
    cmd(OP_PG_B1, 5);
    chk("noErase1", 8'h10, mem[ma(5, 1)]);
    chk("noErase2", 8'h22, mem[ma(5, 2)]);
    cmd(OP_PAGE_ERASE, 5);
    chk("pgErase1", 8'hFF, mem[ma(5, 1)]);
    chk("pgErase263", 8'hFF, mem[ma(5, 263)]);
    cmd(OP_PG_B1, 5);
    chk("erasedProg1", 8'h11, mem[ma(5, 1)]);
  endtask : t_prog_only

  task automatic t_block();
    for (int j = 0; j < 9; j++) mem[ma(40 + j, 9)] = 8'h00;
    cmd(OP_BLOCK_ERASE, 45);
    for (int j = 0; j < 8; j++) chk("blkPage", 8'hFF, mem[ma(40 + j, 9)]);
    chk("nextBlock", 8'h00, mem[ma(48, 9)]);
  endtask : t_block

  task automatic t_thru();
    mem[ma(7, 4)] = 8'h00;
    host.frame(OP_THRU_B1, pa(7) | 24'h000004, 32, 2, 8'h5A);
    wait_done();
    chk("thru4", 8'h5A, mem[ma(7, 4)]);
    chk("thru5", 8'h6B, mem[ma(7, 5)]);
    chk("thru6", 8'h66, mem[ma(7, 6)]);
  endtask : t_thru

  task automatic t_xfer_cmp();
    mem[ma(9, 0)] = 8'h12;
    cmd(OP_XFER_B2, 9);
    cmd(OP_PGE_B2, 11);
    chk("xfer0", 8'h12, mem[ma(11, 0)]);
    chk("xfer1", 8'hFF, mem[ma(11, 1)]);
    mem[ma(11, 263)] = 8'h00;
    cmd(OP_CMP_B2, 11);
    chk("cmpDiff", 8'hD0, statusByte);
    cmd(OP_CMP_B1, 7);
    chk("cmpSame", 8'h90, statusByte);
  endtask : t_xfer_cmp

  task automatic t_rewrite();
    mem[ma(13, 2)] = 8'h7E;
    cmd(OP_REWR_B1, 13);
    chk("rewr2", 8'h7E, mem[ma(13, 2)]);
    cmd(OP_CMP_B1, 13);
    chk("rewrBuf", 8'h90, statusByte);
  endtask : t_rewrite

  task automatic t_short();
    host.frame(OP_PAGE_ERASE, pa(13), 20, 0, 8'h00);
    repeat (30) @(negedge clk_sys);
    chk("shortBusy", 8'h00, {7'h00, busyOe});
    chk("shortKeep", 8'h7E, mem[ma(13, 2)]);
  endtask : t_short

  task automatic t_freeze();
    int n;
    n = 0;
    host.frame(OP_PAGE_ERASE, pa(20), 32, 0, 8'h00);
    @(negedge clk_sys);
    while (busyOe !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    ce = 1'b0;
    repeat (100) @(negedge clk_sys);
    chk("frozenBusy", 8'h02, {6'h00, busyOe, busyOut});
    chk("frozenStat", 8'h10, statusByte & 8'hBF);
    ce = 1'b1;
    wait_done();
  endtask : t_freeze

  initial begin
    for (int i = 0; i < (1 << MEM_ADDR_W); i++) mem[i] = 8'hFF;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    // both buffers hold k*11h at byte k
    host.frame(OP_WR_B1, 24'h000000, 32, PAGE_BYTES, 8'h00);
    host.frame(OP_WR_B2, 24'h000000, 32, PAGE_BYTES, 8'h00);
    repeat (8) @(negedge clk_sys);
    t_prog_erase();
    t_prog_only();
    t_block();
    t_thru();
    t_xfer_cmp();
    t_rewrite();
    t_short();
    t_freeze();
    results();
  end
endmodule : tb
`default_nettype wire
